// [src/tct_thermostat.v]
`timescale 1ns/100ps
`include "tct_regs.vh"

module tct_thermostat #(
    parameter [27:0] CONV9_CYCLES = `TCT_TC9_US * `TCT_CLK_MHZ,
    parameter [27:0] NVWR_CYCLES  = `TCT_NVWR_US * `TCT_CLK_MHZ
) (
    input  wire        core_clk,
    input  wire        arst_n,
    input  wire        busSelPin,
    input  wire        serClkPin,
    input  wire        dqInPin,
    input  wire [11:0] adcSample,
    output wire        dqOutPin,
    output wire        dqOe_n,
    output wire        tempHigh,
    output wire        tempLow,
    output wire        tempCom
);

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    reg  [2:0]  selSync_q;
    reg  [2:0]  clkSync_q;
    reg  [1:0]  dqSync_q;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            selSync_q <= 3'h0;
            clkSync_q <= 3'h7;
            dqSync_q  <= 2'h0;
        end else begin
            selSync_q <= {selSync_q[1:0], busSelPin};
            clkSync_q <= {clkSync_q[1:0], serClkPin};
            dqSync_q  <= {dqSync_q[0], dqInPin};
        end
    end

    wire selLevel = selSync_q[1];
    wire selRise  = selSync_q[1] & ~selSync_q[2];
    wire clkRise  = clkSync_q[1] & ~clkSync_q[2];
    wire clkFall  = ~clkSync_q[1] & clkSync_q[2];
    wire dqBit    = dqSync_q[1];

    // ----------------------------------------------------------------
    // Stored state
    // ----------------------------------------------------------------
    reg  [11:0] result_q;
    reg  [11:0] upperThr_q;
    reg  [11:0] lowerThr_q;
    reg  [1:0]  resSel_q;
    reg         standalone_q;
    reg         singleConv_q;
    reg         highSeen_q;
    reg         lowSeen_q;
    reg  [27:0] nvCnt_q;
    reg         running_q;
    reg         contin_q;
    reg         saRun_q;
    reg  [27:0] convCnt_q;
    reg         tHigh_q;
    reg         tLow_q;
    reg         tCom_q;

    wire nvBusy = (nvCnt_q != `TCT_CNT_ZERO);

    reg  [11:0] resMask;
    always @* begin
        case (resSel_q)
            `TCT_RES_9:  resMask = `TCT_MASK_9;
            `TCT_RES_10: resMask = `TCT_MASK_10;
            `TCT_RES_11: resMask = `TCT_MASK_11;
            default:     resMask = `TCT_MASK_12;
        endcase
    end

    // ----------------------------------------------------------------
    // Serial command slave
    // ----------------------------------------------------------------
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_CMD  = 2'h1;
    localparam [1:0] S_DATA = 2'h2;

    reg  [1:0]  state_q;
    reg  [4:0]  bitCnt_q;
    reg  [7:0]  cmd_q;
    reg  [11:0] rxWord_q;
    reg  [11:0] txWord_q;
    reg         dqOut_q;
    reg         dqOe_n_q;
    reg         upperWrP_q;
    reg         lowerWrP_q;
    reg         cfgWrP_q;
    reg         startP_q;
    reg         stopP_q;
    reg  [11:0] wrData_q;

    wire [7:0]  cmdNext  = {dqBit, cmd_q[7:1]};
    wire [7:0]  cfgByte  = {~running_q, highSeen_q, lowSeen_q, nvBusy,
                            resSel_q, standalone_q, singleConv_q};
    wire        isRead   = (cmd_q == `TCT_CMD_RD_TEMP) || (cmd_q == `TCT_CMD_RD_UPPER) ||
                           (cmd_q == `TCT_CMD_RD_LOWER) || (cmd_q == `TCT_CMD_RD_CFG);
    wire [11:0] rxFull   = {dqBit, rxWord_q[10:0]};

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q    <= S_IDLE;
            bitCnt_q   <= `TCT_BIT_ZERO;
            cmd_q      <= 8'h00;
            rxWord_q   <= 12'h000;
            txWord_q   <= 12'h000;
            dqOut_q    <= 1'b0;
            dqOe_n_q   <= 1'b1;
            upperWrP_q <= 1'b0;
            lowerWrP_q <= 1'b0;
            cfgWrP_q   <= 1'b0;
            startP_q   <= 1'b0;
            stopP_q    <= 1'b0;
            wrData_q   <= 12'h000;
        end else begin
            upperWrP_q <= 1'b0;
            lowerWrP_q <= 1'b0;
            cfgWrP_q   <= 1'b0;
            startP_q   <= 1'b0;
            stopP_q    <= 1'b0;
            if (!selLevel) begin
                state_q  <= S_IDLE;
                dqOe_n_q <= 1'b1;
            end else if (selRise) begin
                state_q  <= S_CMD;
                bitCnt_q <= `TCT_BIT_ZERO;
            end else begin
                case (state_q)
                    S_CMD: begin
                        if (clkRise) begin
                            cmd_q    <= cmdNext;
                            bitCnt_q <= bitCnt_q + `TCT_BIT_ONE;
                            if (bitCnt_q == `TCT_CMD_LAST) begin
                                state_q  <= S_DATA;
                                bitCnt_q <= `TCT_BIT_ZERO;
                                startP_q <= (cmdNext == `TCT_CMD_START);
                                stopP_q  <= (cmdNext == `TCT_CMD_STOP);
                                case (cmdNext)
                                    `TCT_CMD_RD_TEMP:  txWord_q <= result_q;
                                    `TCT_CMD_RD_UPPER: txWord_q <= upperThr_q;
                                    `TCT_CMD_RD_LOWER: txWord_q <= lowerThr_q;
                                    `TCT_CMD_RD_CFG:   txWord_q <= {4'h0, cfgByte};
                                    default:           txWord_q <= 12'h000;
                                endcase
                            end
                        end
                    end
                    S_DATA: begin
                        if (clkRise) begin
                            if (bitCnt_q <= `TCT_WORD_LAST) begin
                                rxWord_q[bitCnt_q[3:0]] <= dqBit;
                            end
                            if (bitCnt_q != `TCT_BIT_SAT) begin
                                bitCnt_q <= bitCnt_q + `TCT_BIT_ONE;
                            end
                            if (bitCnt_q == `TCT_WORD_LAST) begin
                                wrData_q   <= rxFull;
                                upperWrP_q <= (cmd_q == `TCT_CMD_WR_UPPER);
                                lowerWrP_q <= (cmd_q == `TCT_CMD_WR_LOWER);
                            end
                            if (bitCnt_q == `TCT_CFG_LAST) begin
                                wrData_q <= {4'h0, dqBit, rxWord_q[6:0]};
                                cfgWrP_q <= (cmd_q == `TCT_CMD_WR_CFG);
                            end
                        end
                        if (clkFall) begin
                            dqOe_n_q <= ~(isRead && (bitCnt_q <= `TCT_WORD_LAST));
                            if (bitCnt_q <= `TCT_WORD_LAST) begin
                                dqOut_q <= txWord_q[bitCnt_q[3:0]];
                            end
                        end
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencer, thermostat and nonvolatile settings
    // ----------------------------------------------------------------
    wire [27:0] convLen  = CONV9_CYCLES << resSel_q;
    wire [11:0] newRes   = adcSample & resMask;
    wire        geUpper  = $signed(newRes) >= $signed(upperThr_q & resMask);
    wire        leLower  = $signed(newRes) <= $signed(lowerThr_q & resMask);
    wire        convEnd  = running_q && (convCnt_q == `TCT_CNT_ZERO);
    // Stand-alone trigger only while the bus is deselected
    wire        saStart  = standalone_q & ~selLevel & clkFall;
    wire        startReq = startP_q | saStart;
    wire        wrAllow  = ~nvBusy;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_q     <= `TCT_TEMP_RST;
            upperThr_q   <= `TCT_UPPER_RST;
            lowerThr_q   <= `TCT_LOWER_RST;
            resSel_q     <= `TCT_RES_RST;
            standalone_q <= `TCT_STANDA_RST;
            singleConv_q <= `TCT_SINGLE_RST;
            highSeen_q   <= 1'b0;
            lowSeen_q    <= 1'b0;
            nvCnt_q      <= `TCT_CNT_ZERO;
            running_q    <= 1'b0;
            contin_q     <= 1'b0;
            saRun_q      <= 1'b0;
            convCnt_q    <= `TCT_CNT_ZERO;
            tHigh_q      <= 1'b0;
            tLow_q       <= 1'b0;
            tCom_q       <= 1'b0;
        end else begin
            if (nvBusy) begin
                nvCnt_q <= nvCnt_q - `TCT_CNT_ONE;
            end
            if (upperWrP_q && wrAllow) begin
                upperThr_q <= wrData_q & resMask;
                nvCnt_q    <= NVWR_CYCLES;
            end
            if (lowerWrP_q && wrAllow) begin
                lowerThr_q <= wrData_q & resMask;
                nvCnt_q    <= NVWR_CYCLES;
            end
            if (cfgWrP_q && wrAllow) begin
                resSel_q     <= wrData_q[`TCT_CFG_RES_HI:`TCT_CFG_RES_LO];
                standalone_q <= wrData_q[`TCT_CFG_STANDA];
                singleConv_q <= wrData_q[`TCT_CFG_SINGLE];
                nvCnt_q      <= NVWR_CYCLES;
            end
            // A set in the same cycle as a clear wins
            highSeen_q <= (convEnd & geUpper) |
                          (highSeen_q & ~(cfgWrP_q & ~wrData_q[`TCT_CFG_HIGHF]));
            lowSeen_q  <= (convEnd & leLower) |
                          (lowSeen_q & ~(cfgWrP_q & ~wrData_q[`TCT_CFG_LOWF]));

            if (startReq) begin
                running_q <= 1'b1;
                contin_q  <= startP_q ? ~singleConv_q : 1'b1;
                saRun_q   <= ~startP_q;
                convCnt_q <= convLen - `TCT_CNT_ONE;
            end else if (stopP_q || (selRise && saRun_q)) begin
                running_q <= 1'b0;
                saRun_q   <= 1'b0;
            end else if (running_q) begin
                if (convEnd) begin
                    result_q <= newRes;
                    tHigh_q  <= geUpper;
                    tLow_q   <= leLower;
                    if (geUpper) begin
                        tCom_q <= 1'b1;
                    end else if (leLower) begin
                        tCom_q <= 1'b0;
                    end
                    if (contin_q) begin
                        convCnt_q <= convLen - `TCT_CNT_ONE;
                    end else begin
                        running_q <= 1'b0;
                        saRun_q   <= 1'b0;
                    end
                end else begin
                    convCnt_q <= convCnt_q - `TCT_CNT_ONE;
                end
            end
            // Releasing the convert pin lets the current conversion finish as the last
            if (saRun_q && ~selLevel && clkRise) begin
                contin_q <= 1'b0;
            end
        end
    end

    assign dqOutPin = dqOut_q;
    assign dqOe_n   = dqOe_n_q;
    assign tempHigh = tHigh_q;
    assign tempLow  = tLow_q;
    assign tempCom  = tCom_q;

endmodule // tct_thermostat

// [src/tct_regs.vh]
`ifndef TCT_REGS_VH
`define TCT_REGS_VH

// --------------------------------------------------------------------
// Serial framing
// --------------------------------------------------------------------
`define TCT_CMD_W        8
`define TCT_WORD_W       12
`define TCT_CMD_LAST     5'h07
`define TCT_WORD_LAST    5'h0b
`define TCT_CFG_LAST     5'h07
`define TCT_BIT_SAT      5'h1f
`define TCT_BIT_ONE      5'h01
`define TCT_BIT_ZERO     5'h00

// --------------------------------------------------------------------
// Command codes
// --------------------------------------------------------------------
`define TCT_CMD_RD_TEMP  8'haa
`define TCT_CMD_RD_UPPER 8'ha1
`define TCT_CMD_RD_LOWER 8'ha2
`define TCT_CMD_RD_CFG   8'hac
`define TCT_CMD_WR_UPPER 8'h01
`define TCT_CMD_WR_LOWER 8'h02
`define TCT_CMD_WR_CFG   8'h0c
`define TCT_CMD_START    8'h51
`define TCT_CMD_STOP     8'h22

// --------------------------------------------------------------------
// Configuration byte layout
// --------------------------------------------------------------------
`define TCT_CFG_DONE     7
`define TCT_CFG_HIGHF    6
`define TCT_CFG_LOWF     5
`define TCT_CFG_NVBUSY   4
`define TCT_CFG_RES_HI   3
`define TCT_CFG_RES_LO   2
`define TCT_CFG_STANDA   1
`define TCT_CFG_SINGLE   0

// --------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------
`define TCT_TEMP_RST     12'hc40
`define TCT_UPPER_RST    12'h0f0
`define TCT_LOWER_RST    12'h0a0
`define TCT_RES_RST      2'h3
`define TCT_STANDA_RST   1'b0
`define TCT_SINGLE_RST   1'b0

// --------------------------------------------------------------------
// Resolution codes and masks
// --------------------------------------------------------------------
`define TCT_RES_9        2'h0
`define TCT_RES_10       2'h1
`define TCT_RES_11       2'h2
`define TCT_MASK_9       12'hff8
`define TCT_MASK_10      12'hffc
`define TCT_MASK_11      12'hffe
`define TCT_MASK_12      12'hfff

// --------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------
`define TCT_CNT_W        28
`define TCT_CNT_ZERO     28'h0000000
`define TCT_CNT_ONE      28'h0000001
`define TCT_CLK_MHZ      28'd200
`define TCT_TC9_US       28'd93750
`define TCT_NVWR_US      28'd4000

`endif

// [bench/tct_host_model.sv]
`timescale 1ns/100ps
module tct_host_model (
    input  wire logic core_clk,
    input  wire logic dqOutPin,
    input  wire logic dqOe_n,
    output logic      busSelPin,
    output logic      serClkPin,
    output wire logic dqInPin
);
    logic hostOe;
    logic hostBit;
    // Data line has a pull-up, so a released wire reads high
    assign dqInPin = !dqOe_n ? dqOutPin : (hostOe ? hostBit : 1'b1);
    initial begin
        busSelPin = 1'b0;
        serClkPin = 1'b1;
        hostOe    = 1'b0;
        hostBit   = 1'b0;
    end
    // Clock idles high on its pull-up, since a low level while deselected asks
    // for a stand-alone conversion; data changes with the falling edge
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int nb,
                        input bit rd, output logic [11:0] got);
        logic [23:0] sh;
        sh  = {wd, cmd};
        got = 12'h000;
        @(posedge core_clk) busSelPin <= 1'b1;
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < 8 + nb; i++) begin
            serClkPin <= 1'b0;
            hostOe    <= !(rd && i >= 8);
            hostBit   <= sh[i];
            repeat (12) @(posedge core_clk);
            if (rd && i >= 8 && i < 20) got[i-8] = dqInPin;
            serClkPin <= 1'b1;
            repeat (13) @(posedge core_clk);
        end
        // Fewer than 12 data bits here is how a short write is made on purpose
        busSelPin <= 1'b0;
        hostOe    <= 1'b0;
        repeat (20) @(posedge core_clk);
    endtask
    // Convert pulse on the clock pin while the bus is deselected
    task automatic cnv_pulse(input int len);
        @(posedge core_clk) serClkPin <= 1'b0;
        repeat (len) @(posedge core_clk);
        serClkPin <= 1'b1;
    endtask
endmodule // tct_host_model

// [bench/tct_thermostat_sva.sv]
`timescale 1ns/100ps
module tct_thermostat_sva #(
    parameter [27:0] CONV9_CYCLES = 28'd20,
    parameter [27:0] NVWR_CYCLES  = 28'd10
) (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        busSelPin,
    input wire logic        serClkPin,
    input wire logic        dqInPin,
    input wire logic [11:0] adcSample,
    input wire logic        dqOutPin,
    input wire logic        dqOe_n,
    input wire logic        tempHigh,
    input wire logic        tempLow,
    input wire logic        tempCom
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic [2:0]  prevOuts_q;
    logic [27:0] sinceUpd_q;
    logic        anyChg;
    assign anyChg = {tempHigh, tempLow, tempCom} != prevOuts_q;
    // Outputs may only move once per conversion, the shortest being CONV9_CYCLES
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prevOuts_q <= 3'h0;
            sinceUpd_q <= CONV9_CYCLES;
        end else begin
            prevOuts_q <= {tempHigh, tempLow, tempCom};
            if (anyChg) sinceUpd_q <= 28'h0000000;
            else if (sinceUpd_q != CONV9_CYCLES) sinceUpd_q <= sinceUpd_q + 28'h0000001;
        end
    end
    a_reset_outs: assert property ($rose(arst_n) |-> !tempHigh && !tempLow && !tempCom && dqOe_n)
        else $error("outputs not idle after reset");
    a_alarm_excl: assert property (!(tempHigh && tempLow))
        else $error("high and low alarms both set");
    a_high_com: assert property (tempHigh |-> tempCom)
        else $error("hysteresis output low while high alarm set");
    a_low_nocom: assert property (tempLow |-> !tempCom)
        else $error("hysteresis output set while low alarm set");
    a_com_rise: assert property ($rose(tempCom) |-> $rose(tempHigh))
        else $error("hysteresis output rose without high alarm");
    a_com_fall: assert property ($fell(tempCom) |-> $rose(tempLow))
        else $error("hysteresis output fell without low alarm");
    a_upd_space: assert property (anyChg |-> sinceUpd_q >= CONV9_CYCLES - 28'd1)
        else $error("thermostat outputs changed within one conversion");
    a_dout_hold: assert property (serClkPin [*5] |-> $stable(dqOutPin))
        else $error("data out moved while serial clock high");
    a_oe_release: assert property ((!busSelPin) [*6] |-> dqOe_n)
        else $error("data line driven while deselected");
    c_high: cover property ($rose(tempHigh));
    c_low: cover property ($rose(tempLow));
    c_com_clr: cover property ($fell(tempCom));
    c_drive: cover property (!dqOe_n);
endmodule // tct_thermostat_sva

bind tct_thermostat tct_thermostat_sva #(.CONV9_CYCLES(CONV9_CYCLES), .NVWR_CYCLES(NVWR_CYCLES))
    tct_thermostat_sva_inst (.core_clk(core_clk), .arst_n(arst_n), .busSelPin(busSelPin),
    .serClkPin(serClkPin), .dqInPin(dqInPin), .adcSample(adcSample), .dqOutPin(dqOutPin),
    .dqOe_n(dqOe_n), .tempHigh(tempHigh), .tempLow(tempLow), .tempCom(tempCom));

// [bench/tb_top.sv]
`timescale 1ns/100ps
`include "tct_regs.vh"
module tb_top;
    localparam [27:0] CONV9 = 28'd20;
    localparam [27:0] NVWR  = 28'd10;
    logic        core_clk;
    logic        arst_n;
    logic [11:0] adcSample;
    logic [11:0] rdat;
    wire         busSelPin, serClkPin, dqInPin, dqOutPin, dqOe_n, tempHigh, tempLow, tempCom;
    int          errors;
    int          total_checks;

    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;

    tct_thermostat #(.CONV9_CYCLES(CONV9), .NVWR_CYCLES(NVWR)) tct_thermostat_inst (
        .core_clk(core_clk), .arst_n(arst_n), .busSelPin(busSelPin), .serClkPin(serClkPin),
        .dqInPin(dqInPin), .adcSample(adcSample), .dqOutPin(dqOutPin), .dqOe_n(dqOe_n),
        .tempHigh(tempHigh), .tempLow(tempLow), .tempCom(tempCom));
    tct_host_model tct_host_model_inst (.core_clk(core_clk), .dqOutPin(dqOutPin),
        .dqOe_n(dqOe_n), .busSelPin(busSelPin), .serClkPin(serClkPin), .dqInPin(dqInPin));

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Every write waits out the busy time before the next frame
    task automatic cmd_wr(input logic [7:0] c, input logic [15:0] d, input int nb);
        logic [11:0] unused;
        tct_host_model_inst.xfer(c, d, nb, 1'b0, unused);
        repeat (NVWR + 28'd20) @(posedge core_clk);
    endtask
    task automatic cmd_rd(input logic [7:0] c, input int nb, output logic [11:0] got);
        tct_host_model_inst.xfer(c, 16'h0000, nb, 1'b1, got);
    endtask

    task automatic t_reset;
        cmd_rd(`TCT_CMD_RD_TEMP, 12, rdat);
        chk(rdat, `TCT_TEMP_RST);
        cmd_rd(`TCT_CMD_RD_UPPER, 12, rdat);
        chk(rdat, `TCT_UPPER_RST);
        cmd_rd(`TCT_CMD_RD_LOWER, 12, rdat);
        chk(rdat, `TCT_LOWER_RST);
        cmd_rd(`TCT_CMD_RD_CFG, 8, rdat);
        chk(rdat, 12'h08c);
        chk({9'h000, tempHigh, tempLow, tempCom}, 12'h000);
    endtask
    task automatic t_resolution;
        logic [11:0] exp;
        adcSample <= 12'h0a7;
        for (int r = 0; r < 4; r++) begin
            exp = 12'h0a7 & (12'hfff << (3 - r));
            cmd_wr(`TCT_CMD_WR_CFG, {12'h000, r[1:0], 2'b01}, 8);
            cmd_wr(`TCT_CMD_START, 16'h0000, 0);
            repeat ((CONV9 << r) + 28'd10) @(posedge core_clk);
            cmd_rd(`TCT_CMD_RD_TEMP, 12, rdat);
            chk(rdat, exp);
            chk({11'h000, tempLow}, {11'h000, r == 0});
        end
        adcSample <= 12'h100;
        repeat (400) @(posedge core_clk);
        chk({11'h000, tempHigh}, 12'h000);
    endtask
    task automatic t_thresh;
        cmd_wr(`TCT_CMD_WR_CFG, 16'h0001, 8);
        cmd_wr(`TCT_CMD_WR_UPPER, 16'h00ff, 12);
        cmd_rd(`TCT_CMD_RD_UPPER, 12, rdat);
        chk(rdat, 12'h0f8);
        cmd_wr(`TCT_CMD_WR_LOWER, 16'h0055, 8);
        cmd_rd(`TCT_CMD_RD_LOWER, 12, rdat);
        chk(rdat, `TCT_LOWER_RST);
        cmd_wr(`TCT_CMD_WR_LOWER, 16'hf053, 16);
        cmd_rd(`TCT_CMD_RD_LOWER, 12, rdat);
        chk(rdat, 12'h050);
    endtask
    task automatic t_continuous;
        int n;
        adcSample <= 12'h0f8;
        cmd_wr(`TCT_CMD_WR_CFG, 16'h000c, 8);
        cmd_wr(`TCT_CMD_START, 16'h0000, 0);
        n = 0;
        while (tempHigh !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        chk({10'h000, tempHigh, tempCom}, 12'h003);
        adcSample <= 12'h060;
        n = 0;
        while (tempHigh === 1'b1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        chk({11'h000, n >= 155 && n <= 165}, 12'h001);
        chk({10'h000, tempLow, tempCom}, 12'h001);
        adcSample <= 12'h800;
        repeat (170) @(posedge core_clk);
        chk({10'h000, tempLow, tempCom}, 12'h002);
        cmd_wr(`TCT_CMD_STOP, 16'h0000, 0);
        adcSample <= 12'h0f8;
        repeat (400) @(posedge core_clk);
        chk({11'h000, tempHigh}, 12'h000);
        cmd_rd(`TCT_CMD_RD_TEMP, 12, rdat);
        chk(rdat, 12'h800);
        cmd_rd(`TCT_CMD_RD_CFG, 8, rdat);
        chk(rdat, 12'h0ec);
        cmd_wr(`TCT_CMD_WR_CFG, 16'h000c, 8);
        cmd_rd(`TCT_CMD_RD_CFG, 8, rdat);
        chk(rdat, 12'h08c);
    endtask
    task automatic t_standalone;
        adcSample <= 12'h123;
        cmd_wr(`TCT_CMD_WR_CFG, 16'h0002, 8);
        tct_host_model_inst.cnv_pulse(50);
        repeat (200) @(posedge core_clk);
        chk({9'h000, tempHigh, tempLow, tempCom}, 12'h005);
        adcSample <= 12'h800;
        repeat (100) @(posedge core_clk);
        chk({9'h000, tempHigh, tempLow, tempCom}, 12'h005);
        cmd_rd(`TCT_CMD_RD_TEMP, 12, rdat);
        chk(rdat, 12'h120);
        cmd_rd(`TCT_CMD_RD_CFG, 8, rdat);
        chk(rdat, 12'h0c2);
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end
    initial begin
        errors       = 0;
        total_checks = 0;
        arst_n       = 1'b0;
        adcSample    = 12'h000;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_reset();
        t_resolution();
        t_thresh();
        t_continuous();
        t_standalone();
        complete_run();
    end
endmodule // tb_top
